// file: shared/acrs_regs.svh
// register map constants of the converter configuration register set
`ifndef ACRS_REGS_SVH
`define ACRS_REGS_SVH

`define ACRS_ADDR_CONV_MODE   6'h01
`define ACRS_ADDR_IF_MODE     6'h02
`define ACRS_ADDR_FILT_CFG0   6'h28
`define ACRS_ADDR_OFFSET_CALIBRATION_SETUP_ZERO     6'h30
`define ACRS_ADDR_GAIN_CALIBRATION_SETUP_ZERO       6'h38

`define ACRS_RST_CONV_MODE    16'h2000
`define ACRS_RST_IF_MODE      16'h0000
`define ACRS_RST_FILT_CFG0    16'h0500
`define ACRS_RST_OFFSET_CALIBRATION_SETUP_ZERO      24'h800000
`define ACRS_GAIN_TOP_NIBBLE  4'h5
`define ACRS_GAIN_LOW_NIBBLE  4'h0

`define ACRS_MASK_CONV_MODE   16'hA77C
`define ACRS_MASK_IF_MODE     16'h19ED
`define ACRS_MASK_FILT_CFG0   16'h8F7F

`define ACRS_CMD_WEN_BIT      7
`define ACRS_CMD_READ_BIT     6
`define ACRS_LEN_8            5'h08
`define ACRS_LEN_16           5'h10
`define ACRS_LEN_24           5'h18
`define ACRS_ONES_LAST        7'h3F

`endif

// file: shared/acrs_pkg.sv
// types of the converter configuration register set
package acrs_pkg;

	typedef enum logic [2:0] {
		ACRS_ST_CMD = 3'b001,
		ACRS_ST_WR  = 3'b010,
		ACRS_ST_RD  = 3'b100
	} acrs_fsm_t;

	typedef struct packed {
		acrs_fsm_t   fsm;
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_d;
		logic        cs_s1;
		logic        cs_s2;
		logic        din_s1;
		logic        din_s2;
		logic [4:0]  cnt;
		logic [4:0]  len;
		logic [5:0]  addr;
		logic [23:0] rx;
		logic [23:0] tx;
		logic        dout_oe;
		logic [6:0]  ones;
		logic [15:0] conv_mode;
		logic [15:0] if_mode;
		logic [15:0] filt_cfg;
		logic [23:0] offset_cal;
		logic [23:0] gain_cal;
	} acrs_state_t;

endpackage : acrs_pkg

// file: logic/acrs_top.sv
// serial-port register set: mode, interface, filter and calibration registers
`timescale 1ns/1ps
`include "acrs_regs.svh"

module acrs_top #(
	parameter logic [15:0] GAIN_FACTORY_MID = 16'h0000 // arbitrary trim digits
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// serial port pins
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        din_i,
	output logic             dout_o,
	output logic             dout_oe_o,
	// configuration to the converter core
	output logic [15:0]      converter_mode_o,
	output logic [15:0]      serial_interface_mode_o,
	output logic [15:0]      filter_config_setup_zero_o,
	output logic [23:0]      offset_calibration_setup_zero_o,
	output logic [23:0]      gain_calibration_setup_zero_o
);

	localparam logic [23:0] GAIN_RESET =
		{`ACRS_GAIN_TOP_NIBBLE, GAIN_FACTORY_MID, `ACRS_GAIN_LOW_NIBBLE};

	acrs_pkg::acrs_state_t st;
	acrs_pkg::acrs_state_t next_st;

	function automatic acrs_pkg::acrs_state_t regs_default(
		input acrs_pkg::acrs_state_t s
	);
		acrs_pkg::acrs_state_t r;
		r = s;
		r.conv_mode  = `ACRS_RST_CONV_MODE;
		r.if_mode    = `ACRS_RST_IF_MODE;
		r.filt_cfg   = `ACRS_RST_FILT_CFG0;
		r.offset_cal = `ACRS_RST_OFFSET_CALIBRATION_SETUP_ZERO;
		r.gain_cal   = GAIN_RESET;
		return r;
	endfunction : regs_default

	localparam acrs_pkg::acrs_state_t RESET_ST = regs_default('{
		fsm:     acrs_pkg::ACRS_ST_CMD,
		sclk_s1: 1'b1,
		sclk_s2: 1'b1,
		sclk_d:  1'b1,
		cs_s1:   1'b1,
		cs_s2:   1'b1,
		default: '0
	});

	// data phase length in bits; unmapped addresses take one byte
	function automatic logic [4:0] reg_len(input logic [5:0] a);
		case (a)
			`ACRS_ADDR_CONV_MODE,
			`ACRS_ADDR_IF_MODE,
			`ACRS_ADDR_FILT_CFG0: reg_len = `ACRS_LEN_16;
			`ACRS_ADDR_OFFSET_CALIBRATION_SETUP_ZERO,
			`ACRS_ADDR_GAIN_CALIBRATION_SETUP_ZERO:     reg_len = `ACRS_LEN_24;
			default:              reg_len = `ACRS_LEN_8;
		endcase
	endfunction : reg_len

	// read data left aligned so the msb leaves first
	function automatic logic [23:0] rd_word(
		input acrs_pkg::acrs_state_t s,
		input logic [5:0]            a
	);
		case (a)
			`ACRS_ADDR_CONV_MODE: rd_word = {s.conv_mode, 8'h00};
			`ACRS_ADDR_IF_MODE:   rd_word = {s.if_mode, 8'h00};
			`ACRS_ADDR_FILT_CFG0: rd_word = {s.filt_cfg, 8'h00};
			`ACRS_ADDR_OFFSET_CALIBRATION_SETUP_ZERO:   rd_word = s.offset_cal;
			`ACRS_ADDR_GAIN_CALIBRATION_SETUP_ZERO:     rd_word = s.gain_cal;
			default:              rd_word = 24'h000000;
		endcase
	endfunction : rd_word

	logic       rise;
	logic [4:0] cnt_inc;
	logic [23:0] rx_new;

	always_comb
	begin
		next_st = st;
		// pins pass two flip-flops before any logic looks at them
		next_st.sclk_s1 = sclk_i;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d  = st.sclk_s2;
		next_st.cs_s1   = cs_n_i;
		next_st.cs_s2   = st.cs_s1;
		next_st.din_s1  = din_i;
		next_st.din_s2  = st.din_s1;
		next_st.dout_oe = ~st.cs_s2;
		// host samples on the rising edge; we act three clocks later, so
		// shifting the output here is already past the host's sample point
		rise    = st.sclk_s2 & ~st.sclk_d;
		cnt_inc = st.cnt + 5'h01;
		rx_new  = {st.rx[22:0], st.din_s2};
		if (st.cs_s2)
		begin
			// deselect aborts any transfer, registers keep their contents
			next_st.fsm = acrs_pkg::ACRS_ST_CMD;
			next_st.cnt = '0;
			next_st.ones = '0;
		end
		else if (rise)
		begin
			next_st.rx  = rx_new;
			next_st.cnt = cnt_inc;
			next_st.ones = st.din_s2 ? st.ones + 7'h01 : 7'h00;
			if (st.fsm == acrs_pkg::ACRS_ST_RD)
			begin
				next_st.tx = {st.tx[22:0], 1'b0};
			end
			case (st.fsm)
				acrs_pkg::ACRS_ST_CMD:
				begin
					if (cnt_inc == `ACRS_LEN_8)
					begin
						next_st.cnt  = '0;
						next_st.addr = rx_new[5:0];
						next_st.len  = reg_len(rx_new[5:0]);
						if (rx_new[`ACRS_CMD_WEN_BIT])
						begin
							next_st.fsm = acrs_pkg::ACRS_ST_CMD;
						end
						else if (rx_new[`ACRS_CMD_READ_BIT])
						begin
							next_st.fsm = acrs_pkg::ACRS_ST_RD;
							next_st.tx  = rd_word(st, rx_new[5:0]);
						end
						else
						begin
							next_st.fsm = acrs_pkg::ACRS_ST_WR;
						end
					end
				end
				acrs_pkg::ACRS_ST_WR:
				begin
					if (cnt_inc == st.len)
					begin
						next_st.fsm = acrs_pkg::ACRS_ST_CMD;
						next_st.cnt = '0;
						case (st.addr)
							`ACRS_ADDR_CONV_MODE:
								next_st.conv_mode = rx_new[15:0] & `ACRS_MASK_CONV_MODE;
							`ACRS_ADDR_IF_MODE:
								next_st.if_mode = rx_new[15:0] & `ACRS_MASK_IF_MODE;
							`ACRS_ADDR_FILT_CFG0:
								next_st.filt_cfg = rx_new[15:0] & `ACRS_MASK_FILT_CFG0;
							`ACRS_ADDR_OFFSET_CALIBRATION_SETUP_ZERO:
								next_st.offset_cal = rx_new;
							`ACRS_ADDR_GAIN_CALIBRATION_SETUP_ZERO:
								next_st.gain_cal = rx_new;
							default:
								next_st.fsm = acrs_pkg::ACRS_ST_CMD;
						endcase
					end
				end
				acrs_pkg::ACRS_ST_RD:
				begin
					if (cnt_inc == st.len)
					begin
						next_st.fsm = acrs_pkg::ACRS_ST_CMD;
						next_st.cnt = '0;
					end
				end
				default:
				begin
					next_st.fsm = acrs_pkg::ACRS_ST_CMD;
					next_st.cnt = '0;
				end
			endcase
			// 64 consecutive ones on din resets interface and registers alike
			if (st.din_s2 && st.ones == `ACRS_ONES_LAST)
			begin
				next_st      = regs_default(next_st);
				next_st.fsm  = acrs_pkg::ACRS_ST_CMD;
				next_st.cnt  = '0;
				next_st.ones = '0;
				next_st.tx   = '0;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			st <= RESET_ST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign dout_o                          = st.tx[23];
	assign dout_oe_o                       = st.dout_oe;
	assign converter_mode_o                = st.conv_mode;
	assign serial_interface_mode_o         = st.if_mode;
	assign filter_config_setup_zero_o      = st.filt_cfg;
	assign offset_calibration_setup_zero_o = st.offset_cal;
	assign gain_calibration_setup_zero_o   = st.gain_cal;

endmodule : acrs_top

// file: test/acrs_properties.sv
// port assertions for the serial register set
`timescale 1ns/1ps
module acrs_properties (
	input wire logic	sys_clk_i,
	input wire logic	sys_rst_i,
	input wire logic	cs_n_i,
	input wire logic	dout_oe_o,
	input wire logic [15:0]	converter_mode_o,
	input wire logic [15:0]	serial_interface_mode_o,
	input wire logic [15:0]	filter_config_setup_zero_o,
	input wire logic [23:0]	offset_calibration_setup_zero_o,
	input wire logic [23:0]	gain_calibration_setup_zero_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	mode_rst_a: assert property ($fell(sys_rst_i) |-> converter_mode_o == 16'h2000)
		else $error("mode reset");
	ifm_rst_a: assert property ($fell(sys_rst_i) |-> serial_interface_mode_o == 16'h0)
		else $error("if reset");
	filt_rst_a: assert property ($fell(sys_rst_i) |-> filter_config_setup_zero_o == 16'h0500)
		else $error("filter reset");
	cal_rst_a: assert property ($fell(sys_rst_i) |-> offset_calibration_setup_zero_o == 24'h800000
		&& gain_calibration_setup_zero_o[23:20] == 4'h5 && gain_calibration_setup_zero_o[3:0] == 4'h0)
		else $error("cal reset");
	mode_resv_a: assert property ((converter_mode_o & 16'h5883) == 16'h0)
		else $error("mode reserved");
	ifm_resv_a: assert property ((serial_interface_mode_o & 16'hE612) == 16'h0)
		else $error("if reserved");
	filt_resv_a: assert property ((filter_config_setup_zero_o & 16'h7080) == 16'h0)
		else $error("filter reserved");
	oe_idle_a: assert property (cs_n_i [*4] |=> !dout_oe_o)
		else $error("dout driven idle");
	cover property ($rose(dout_oe_o));
	cover property ($changed(converter_mode_o));
	cover property ($changed(gain_calibration_setup_zero_o));
endmodule : acrs_properties
bind acrs_top acrs_properties chk (.sys_clk_i, .sys_rst_i, .cs_n_i, .dout_oe_o, .converter_mode_o,
	.serial_interface_mode_o, .filter_config_setup_zero_o, .offset_calibration_setup_zero_o,
	.gain_calibration_setup_zero_o);

// file: test/acrs_host.sv
// serial host model for the register port, clock idles high
`timescale 1ns/1ps
module acrs_host (
	// serial pins
	output logic		sclk_o,
	output logic		cs_n_o,
	output logic		din_o,
	input wire logic	dout_i
);
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// msb first; data changes on the falling edge so it is steady at the rising one
	task xfer(input logic [63:0] w, input int n, output logic [23:0] r);
		r = 24'h0;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			#25 sclk_o = 1'b0;
			din_o = w[i];
			#25 sclk_o = 1'b1;
			r = {r[22:0], dout_i};
		end
		#25 cs_n_o = 1'b1;
		din_o = ~din_o; // released line must not look held
		#50;
	endtask : xfer
endmodule : acrs_host

// file: test/acrs_top_tb.sv
// bench: register set driven through a host model
`timescale 1ns/1ps
module acrs_top_tb;
	logic		sys_clk_i = 1'b0;
	logic		sys_rst_i = 1'b1;
	logic		sclk_i, cs_n_i, din_i, dout_o;
	logic [23:0]	r;
	logic [15:0]	cm;
	int		errors = 0, checked = 0, cyc = 0;
	logic [5:0]	ta [5] = '{6'h01, 6'h02, 6'h28, 6'h30, 6'h38};
	int		tn [5] = '{16, 16, 16, 24, 24};
	logic [23:0]	tr [4] = '{24'h2000, 24'h0, 24'h500, 24'h800000};
	logic [23:0]	tw [5] = '{24'hFFFF, 24'hFFFF, 24'hFFFF, 24'h123456, 24'hABCDEF};
	logic [23:0]	te [5] = '{24'hA77C, 24'h19ED, 24'h8F7F, 24'h123456, 24'hABCDEF};
	acrs_top uut (.sys_clk_i, .sys_rst_i, .sclk_i, .cs_n_i, .din_i, .dout_o, .dout_oe_o(),
		.converter_mode_o(cm), .serial_interface_mode_o(), .filter_config_setup_zero_o(),
		.offset_calibration_setup_zero_o(), .gain_calibration_setup_zero_o());
	acrs_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));
	initial
	begin
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one frame: command byte, then n data bits
	task acc(input logic [5:0] a, input logic rd, input int n, input logic [23:0] d);
		host.xfer((64'({1'b0, rd, a}) << n) | 64'(d), n + 8, r);
		r = r & ((24'h1 << n) - 24'h1);
	endtask : acc
	task final_report;
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			errors++;
			final_report();
		end
	end
	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		for (int i = 0; i < 4; i++)
		begin
			acc(ta[i], 1'b1, tn[i], 24'h0);
			chk("reset value", r, tr[i]);
		end
		acc(6'h38, 1'b1, 24, 24'h0);
		chk("gain digits", {16'h0, r[23:20], r[3:0]}, 24'h50);
		for (int i = 0; i < 5; i++)
		begin
			acc(ta[i], 1'b0, tn[i], tw[i]);
			acc(ta[i], 1'b1, tn[i], 24'h0);
			chk("readback", r, te[i]);
		end
		host.xfer({8'h01, 16'h0010, 8'h41, 16'h0}, 48, r);
		chk("frame", {8'h0, r[15:0]}, 24'h10);
		chk("mode pin", {8'h0, cm}, 24'h10);
		acc(6'h05, 1'b1, 8, 24'h0);
		chk("unmapped", r, 24'h0);
		@(posedge sys_clk_i);
		#1 sys_rst_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
		acc(6'h01, 1'b1, 16, 24'h0);
		chk("mode after reset", r, 24'h2000);
		final_report();
	end
endmodule : acrs_top_tb
